/* File: design/ffs_top.sv */
// Flash command status, fault status and fault interrupt enable registers on AHB-Lite.
// Assumes the command sequencer, ECC decoder and protection logic sit outside and
// report through one-cycle event pulses; launches leave as a one-cycle pulse.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module ffs_top
	import ffs_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Controller events
	input  ffs_event_t       events,
	input  wire logic        reset_seq_double_fault,
	// Controller side
	output logic             cmd_launch,
	output logic             seq_start_allowed,
	output logic             fault_irq
);

	ffs_addr_phase_t   phase;
	ffs_state_t        state;
	ffs_state_t        next_state;
	logic              wr_en;
	logic              wr_irq_en;
	logic              wr_status;
	logic              wr_fault;
	logic              wr_config;
	logic [1:0]        irq_enable;
	logic              cmd_complete;
	logic              access_err;
	logic              prot_viol;
	logic [STATUS_FIELD_W-1:0] status_field;
	logic              ignore_sf;
	logic              force_df;
	logic [1:0]        fault_flags;
	logic [1:0]        fault_clear;
	logic              launch_req;
	logic              reset_seen;

	// Register index decode shared by all write strobes
	function automatic logic hit(input ffs_addr_phase_t p, input logic [IDX_W-1:0] idx);
		hit = p.valid & p.write & (p.index == idx);
	endfunction

	ffs_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.phase     (phase),
		.hreadyout (hreadyout),
		.hresp     (hresp)
	);

	// Only whole-word transfers are used; hsize is accepted but not decoded
	assign wr_en     = (hsize == hsize) & 1'b1;
	assign wr_irq_en = wr_en & hit(phase, IDX_FAULT_IRQ_EN);
	assign wr_status = wr_en & hit(phase, IDX_CMD_STATUS);
	assign wr_fault  = wr_en & hit(phase, IDX_FAULT_STATUS);
	assign wr_config = wr_en & hit(phase, IDX_FLASH_CONFIG);

	// Both enable bits are plain read/write storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable <= 2'h0;
		end else if (wr_irq_en) begin
			irq_enable[DOUBLE_BIT] <= hwdata[DOUBLE_BIT];
			irq_enable[SINGLE_BIT] <= hwdata[SINGLE_BIT];
		end
	end

	// Configuration bits that steer fault reporting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ignore_sf <= 1'b0;
			force_df  <= 1'b0;
		end else if (wr_config) begin
			ignore_sf <= hwdata[IGNORE_SF_BIT];
			force_df  <= hwdata[FORCE_DF_BIT];
		end
	end

	// A launch needs an idle controller and both error flags clear
	assign launch_req = wr_status & hwdata[CMD_COMPLETE_BIT] & cmd_complete
		& ~access_err & ~prot_viol;
	assign cmd_launch        = launch_req;
	assign seq_start_allowed = ~prot_viol;

	always_comb begin
		next_state = state;
		case (state)
			FFS_IDLE: begin
				if (launch_req) begin
					next_state = FFS_RUN;
				end
			end
			FFS_RUN: begin
				if (events.cmd_done | events.seq_violation | events.illegal_cmd | events.protect_hit) begin
					next_state = FFS_DONE;
				end
			end
			FFS_DONE: begin
				// A launch in the completion cycle must not be lost, or the flag would stay low forever
				next_state = FFS_IDLE;
				if (launch_req) begin
					next_state = FFS_RUN;
				end
			end
			default: begin
				next_state = FFS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= FFS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Completion flag falls on launch and rises on completion or violation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_complete <= 1'b1;
		end else if (launch_req) begin
			cmd_complete <= 1'b0;
		end else if (state == FFS_RUN && next_state == FFS_DONE) begin
			cmd_complete <= 1'b1;
		end
	end

	// Error flags: the hardware set beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			access_err <= 1'b0;
		end else begin
			access_err <= events.seq_violation | events.illegal_cmd
				| (access_err & ~(wr_status & hwdata[ACCESS_ERR_BIT]));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prot_viol <= 1'b0;
		end else begin
			prot_viol <= events.protect_hit
				| (prot_viol & ~(wr_status & hwdata[PROT_VIOL_BIT]));
		end
	end

	// Status field is read-only; loaded from the reset sequence, then per command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_field <= STATUS_FIELD_RST;
			reset_seen   <= 1'b0;
		end else begin
			reset_seen <= 1'b1;
			if (!reset_seen && reset_seq_double_fault) begin
				status_field <= {STATUS_FIELD_W{1'b1}};
			end else if (launch_req) begin
				status_field <= STATUS_FIELD_RST;
			end else if (state == FFS_RUN && events.cmd_error) begin
				status_field <= events.cmd_error_code;
			end
		end
	end

	assign fault_clear = wr_fault ? hwdata[1:0] : 2'h0;

	ffs_fault_flags u_flags (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.array_read          (events.array_read),
		.read_single_fault   (events.read_single_fault),
		.read_double_fault   (events.read_double_fault),
		.read_busy_block     (events.read_busy_block),
		.ignore_single_fault (ignore_sf),
		.force_double_fault  (force_df),
		.clear_mask          (fault_clear),
		.irq_enable          (irq_enable),
		.fault_flags         (fault_flags),
		.fault_irq           (fault_irq)
	);

	// Read data registered at the address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= WORD_ZERO;
		end else if (hready) begin
			hrdata <= WORD_ZERO;
			if (hsel && !hwrite) begin
				case (haddr[ADDR_LSB +: IDX_W])
					IDX_FAULT_IRQ_EN: begin
						hrdata[1:0] <= irq_enable;
					end
					IDX_CMD_STATUS: begin
						// Bits 6 and 2 stay zero
						hrdata[CMD_COMPLETE_BIT] <= cmd_complete;
						hrdata[ACCESS_ERR_BIT]   <= access_err;
						hrdata[PROT_VIOL_BIT]    <= prot_viol;
						hrdata[BUSY_BIT]         <= (state == FFS_RUN);
						hrdata[STATUS_FIELD_LSB +: STATUS_FIELD_W] <= status_field;
					end
					IDX_FAULT_STATUS: begin
						hrdata[1:0] <= fault_flags;
					end
					IDX_FLASH_CONFIG: begin
						hrdata[IGNORE_SF_BIT] <= ignore_sf;
						hrdata[FORCE_DF_BIT]  <= force_df;
					end
					default: begin
						hrdata <= WORD_ZERO;
					end
				endcase
			end
		end
	end

endmodule

/* File: design/ffs_pkg.sv */
// Constants, register map and carrier types for the flash status and fault-flag block.
// Assumes a single AHB-Lite master and one clock domain; events arrive as one-cycle pulses.
// Contract
// - Enable bit 1 gates the double-fault flag onto the fault interrupt.
// - Enable bit 0 gates the single-fault flag onto the fault interrupt.
// - Writing 1 to completion bit 7 launches; flag low while running, set at end.
// - Access error bit 5 set on sequence violation or illegal command; write 1 clears.
// - While access error is set, writes clearing the completion flag are ignored.
// - Protection violation bit 4 set on protected program/erase; write 1 clears.
// - While protection violation is set, no launch and no new write sequence.
// - Busy bit 3 reads 1 while the controller executes a command, else 0.
// - Status bits 2 and 6 are reserved, read 0, ignore writes.
// - Completion status bits 1:0 set when an error occurs in a command or reset.
// - Status after reset may differ if a double fault hits the reset sequence.
// - Double-fault flag bit 1 set on double fault or busy-block read; write 1 clears.
// - Single-fault flag bit 0 set on corrected fault or busy-block read unless ignored.
// - A genuine ECC fault sets at most one of the two fault flags; with force-double-fault set and single faults not ignored, a corrected fault sets both.
// - A read colliding with a running command sets both fault flags; with ignore-single-fault set, only the double-fault flag.
// - Both enable bits are readable and writable.
// - Completion, access error, violation bits writable; busy and status field read-only.
// - Ignore-single-fault suppresses single-fault reporting and its interrupt.
// - Force-double-fault makes every array read set the double-fault flag.
package ffs_pkg;

	// Register indices; each register sits in its own word, byte address is four times the index
	localparam logic [3:0]  IDX_FAULT_IRQ_EN  = 4'h5;
	localparam logic [3:0]  IDX_CMD_STATUS    = 4'h6;
	localparam logic [3:0]  IDX_FAULT_STATUS  = 4'h7;
	// Own register holding the configuration bits that live elsewhere in the controller
	localparam logic [3:0]  IDX_FLASH_CONFIG  = 4'h4;
	localparam int          ADDR_LSB          = 2;
	localparam int          IDX_W             = 4;

	// Command status fields
	localparam int          CMD_COMPLETE_BIT  = 7;
	localparam int          ACCESS_ERR_BIT    = 5;
	localparam int          PROT_VIOL_BIT     = 4;
	localparam int          BUSY_BIT          = 3;
	localparam int          STATUS_FIELD_LSB  = 0;
	localparam int          STATUS_FIELD_W    = 2;

	// Fault enable / fault status fields
	localparam int          DOUBLE_BIT        = 1;
	localparam int          SINGLE_BIT        = 0;

	// Flash configuration fields
	localparam int          IGNORE_SF_BIT     = 4;
	localparam int          FORCE_DF_BIT      = 1;

	localparam logic [1:0]  STATUS_FIELD_RST  = 2'h0;
	localparam logic [31:0] WORD_ZERO         = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ        = 2'h3;

	// Controller sequencing states
	typedef enum logic [2:0] {
		FFS_IDLE = 3'b001,
		FFS_RUN  = 3'b010,
		FFS_DONE = 3'b100
	} ffs_state_t;

	// Events from the command sequencer and array read path
	typedef struct packed {
		logic       seq_violation;
		logic       illegal_cmd;
		logic       protect_hit;
		logic       cmd_done;
		logic       cmd_error;
		logic [1:0] cmd_error_code;
		logic       array_read;
		logic       read_single_fault;
		logic       read_double_fault;
		logic       read_busy_block;
	} ffs_event_t;

	// Captured AHB address phase
	typedef struct packed {
		logic             valid;
		logic             write;
		logic [IDX_W-1:0] index;
	} ffs_addr_phase_t;

endpackage

/* File: design/ffs_fault_flags.sv */
// Sticky write-one-to-clear fault flags and the fault interrupt request.
// Assumes the read events are single-cycle pulses on hclk.
`timescale 1ns/1ps
module ffs_fault_flags
	import ffs_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Read-path events
	input  wire logic       array_read,
	input  wire logic       read_single_fault,
	input  wire logic       read_double_fault,
	input  wire logic       read_busy_block,
	input  wire logic       ignore_single_fault,
	input  wire logic       force_double_fault,
	// Software clear and enables
	input  wire logic [1:0] clear_mask,
	input  wire logic [1:0] irq_enable,
	// Results
	output logic      [1:0] fault_flags,
	output logic            fault_irq
);

	logic set_double;
	logic set_single;

	// A true double fault wins over a single one, so one ECC fault lights both only when force_double_fault is set
	assign set_double = (array_read & (read_double_fault | read_busy_block | force_double_fault));
	assign set_single = array_read & ~ignore_single_fault
		& ((read_single_fault & ~read_double_fault) | read_busy_block);

	// Set wins over a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_flags <= 2'h0;
		end else begin
			fault_flags[DOUBLE_BIT] <= set_double | (fault_flags[DOUBLE_BIT] & ~clear_mask[DOUBLE_BIT]);
			fault_flags[SINGLE_BIT] <= set_single | (fault_flags[SINGLE_BIT] & ~clear_mask[SINGLE_BIT]);
		end
	end

	// Ignoring single faults also hides a flag left over from before the bit was set
	assign fault_irq = (fault_flags[DOUBLE_BIT] & irq_enable[DOUBLE_BIT])
		| (fault_flags[SINGLE_BIT] & irq_enable[SINGLE_BIT] & ~ignore_single_fault);

endmodule

/* File: design/ffs_ahb_slave.sv */
// AHB-Lite slave front end: captures the address phase that ffs_top decodes into write strobes.
// Assumes one master, single word transfers; always ready, always OKAY.
`timescale 1ns/1ps
module ffs_ahb_slave
	import ffs_pkg::*;
(
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB address phase
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic              hready,
	// Decoded data-phase access
	output ffs_addr_phase_t        phase,
	output logic                   hreadyout,
	output logic                   hresp
);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= '0;
		end else if (hready) begin
			phase.valid <= hsel & ((htrans == HTRANS_NONSEQ) | (htrans == HTRANS_SEQ));
			phase.write <= hwrite;
			phase.index <= haddr[ADDR_LSB +: IDX_W];
		end
	end

	// Zero wait states: register writes take effect at the end of the data phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule

/* File: bench/ffs_status_chk.sv */
// Port-level assertions for the flash status and fault-flag block.
// Bound to ffs_top; expects hready to be fed back from hreadyout.
`timescale 1ns/1ps
module ffs_status_chk
	import ffs_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Controller side
	input ffs_event_t       events,
	input wire logic        cmd_launch,
	input wire logic        seq_start_allowed,
	input wire logic        fault_irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       dp_valid;
	logic       dp_write;
	logic [3:0] dp_idx;
	logic       st_wr;
	// Data-phase view, so a register write can be told from an idle cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_idx   <= 4'h0;
		end else begin
			dp_valid <= hsel && hready && htrans[1] && (haddr[31:6] == 26'h000_0000);
			dp_write <= hwrite;
			dp_idx   <= haddr[5:2];
		end
	end
	assign st_wr = dp_valid && dp_write && (dp_idx == IDX_CMD_STATUS);
	launch_source_a: assert property (cmd_launch |-> st_wr && hwdata[CMD_COMPLETE_BIT])
		else $error("launch without a status write of one");
	launch_single_a: assert property (cmd_launch |=> !cmd_launch)
		else $error("launch repeated while running");
	launch_blocked_a: assert property (cmd_launch |-> seq_start_allowed)
		else $error("launch while protection violation set");
	viol_set_a: assert property (events.protect_hit |=> !seq_start_allowed)
		else $error("protection hit did not block sequences");
	viol_hold_a: assert property (!seq_start_allowed && !st_wr |=> !seq_start_allowed)
		else $error("protection violation dropped without a clear");
	viol_clear_a: assert property (!seq_start_allowed && st_wr && hwdata[PROT_VIOL_BIT] &&
		!events.protect_hit |=> seq_start_allowed)
		else $error("protection violation not cleared by write one");
	// Writing the configuration register may hide a single-fault request, so it counts as software action
	irq_hold_a: assert property (fault_irq && !(dp_valid && dp_write && (dp_idx == IDX_FAULT_STATUS
		|| dp_idx == IDX_FAULT_IRQ_EN || dp_idx == IDX_FLASH_CONFIG)) |=> fault_irq)
		else $error("fault interrupt dropped without software action");
	irq_quiet_a: assert property (!fault_irq && !(dp_valid && dp_write) && !events.array_read |=> !fault_irq)
		else $error("fault interrupt rose without a cause");
	rsvd_zero_a: assert property (dp_valid && !dp_write && dp_idx == IDX_CMD_STATUS
		|-> hrdata[6] == 1'b0 && hrdata[2] == 1'b0)
		else $error("reserved status bit read as one");
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the flash status block: AHB-Lite tasks, event pulses, verdict.
// Assumes a zero-wait-state slave; hready is fed back from hreadyout.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
	import ffs_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	ffs_event_t  events;
	logic        rst_df;
	logic        cmd_launch;
	logic        seq_start_allowed;
	logic        fault_irq;
	logic [31:0] q;
	logic [7:0]  n_launch = 8'h00;
	logic [7:0]  l0;
	int          n_fail;
	int          checks_done;
	ffs_top u_ffs_top(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .events, .reset_seq_double_fault(rst_df),
		.cmd_launch, .seq_start_allowed, .fault_irq);
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Launch is a one-cycle combinational pulse, counted mid-cycle to stay clear of the edge
	always @(negedge hclk) if (cmd_launch === 1'b1) n_launch <= n_launch + 8'h01;
	task automatic test_done;
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic pulse(input ffs_event_t e);
		@(posedge hclk);
		events <= e;
		@(posedge hclk);
		events <= '0;
	endtask
	task automatic do_reset(input logic df);
		hresetn <= 1'b0;
		rst_df  <= df;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rst_df  <= 1'b0;
	endtask
	task automatic t_reset_map;
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q, 32'h0000_0080)
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q, 32'h0000_0000)
		bus(1'b1, 32'h0000_0020, 32'hFFFF_FFFF);
		bus(1'b0, 32'h0000_0020, 32'h0);
		`CHK(q, 32'h0000_0000)
	endtask
	task automatic t_launch;
		l0 = n_launch;
		bus(1'b1, 32'h0000_0018, 32'h80);
		bus(1'b1, 32'h0000_0018, 32'h80);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h08)
		`CHK(n_launch, l0 + 8'h01)
		pulse(11'h060);
		pulse(11'h080);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h82)
		bus(1'b1, 32'h0000_0018, 32'h80);
		pulse(11'h080);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h80)
		`CHK(n_launch, l0 + 8'h02)
	endtask
	task automatic t_access;
		pulse(11'h200);
		l0 = n_launch;
		bus(1'b1, 32'h0000_0018, 32'h80);
		bus(1'b1, 32'h0000_0018, 32'h00);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'hA0)
		`CHK(n_launch, l0)
		bus(1'b1, 32'h0000_0018, 32'h20);
		pulse(11'h400);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'hA0)
		bus(1'b1, 32'h0000_0018, 32'h20);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h80)
	endtask
	task automatic t_prot;
		pulse(11'h100);
		l0 = n_launch;
		bus(1'b1, 32'h0000_0018, 32'h80);
		bus(1'b1, 32'h0000_0018, 32'h4C);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h90)
		`CHK(seq_start_allowed, 1'b0)
		`CHK(n_launch, l0)
		bus(1'b1, 32'h0000_0018, 32'h10);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h80)
	endtask
	task automatic t_fault;
		bus(1'b1, 32'h0000_0014, 32'hFF);
		bus(1'b0, 32'h0000_0014, 32'h0);
		`CHK(q[7:0], 8'h03)
		bus(1'b1, 32'h0000_0014, 32'h02);
		pulse(11'h00C);
		bus(1'b1, 32'h0000_001C, 32'h00);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h01)
		`CHK(fault_irq, 1'b0)
		bus(1'b1, 32'h0000_0014, 32'h01);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(fault_irq, 1'b1)
		bus(1'b1, 32'h0000_001C, 32'h01);
		pulse(11'h00A);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h02)
		`CHK(fault_irq, 1'b0)
		bus(1'b1, 32'h0000_0014, 32'h02);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(fault_irq, 1'b1)
		bus(1'b1, 32'h0000_001C, 32'h02);
		pulse(11'h00E);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h02)
		bus(1'b1, 32'h0000_001C, 32'h03);
		pulse(11'h009);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h03)
		bus(1'b1, 32'h0000_001C, 32'h03);
		bus(1'b1, 32'h0000_0010, 32'h10);
		pulse(11'h00C);
		pulse(11'h009);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h02)
		bus(1'b1, 32'h0000_001C, 32'h03);
		bus(1'b1, 32'h0000_0010, 32'h02);
		pulse(11'h008);
		bus(1'b0, 32'h0000_001C, 32'h0);
		`CHK(q[7:0], 8'h02)
		`CHK(fault_irq, 1'b1)
	endtask
	initial begin
		hresetn     = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hwdata      = 32'h0;
		events      = '0;
		rst_df      = 1'b0;
		n_fail      = 0;
		checks_done = 0;
		do_reset(1'b0);
		t_reset_map();
		t_launch();
		t_access();
		t_prot();
		t_fault();
		do_reset(1'b1);
		bus(1'b0, 32'h0000_0018, 32'h0);
		`CHK(q[7:0], 8'h83)
		test_done();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		test_done();
	end
endmodule
bind ffs_top ffs_status_chk u_ffs_status_chk(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .events, .cmd_launch, .seq_start_allowed, .fault_irq);
